// ==== hw/pbs_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the power button block.
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
`define PBS_CLK_MHZ        100
`define PBS_DEBOUNCE_MS    16
`define PBS_HOLD_MS        4000
`define PBS_MS_CYCLES      (`PBS_CLK_MHZ * 1000)
`define PBS_DEBOUNCE_CYC   (`PBS_DEBOUNCE_MS * `PBS_MS_CYCLES)
`define PBS_HOLD_MSEC      (`PBS_HOLD_MS)
`define PBS_OFF_CTRL       12'h000
`define PBS_OFF_STATUS     12'h004
`define PBS_OFF_MASK       12'h008
`define PBS_OFF_STATE      12'h00C
`define PBS_CTRL_CTL_EN    0
`define PBS_CTRL_MGT_EN    1
`define PBS_CTRL_RING_EN   2
`define PBS_CTRL_SLEEP     3
`define PBS_ST_PRESS       0
`define PBS_ST_WAKE        1
`define PBS_ST_CTLINT      2
`define PBS_ST_MGTINT      3
`define PBS_ST_OVERRIDE    4
`define PBS_ST_RING        5
`define PBS_NSTAT          6
`define PBS_CTRL_RST       4'h0
`define PBS_MASK_RST       6'h00
`endif

// ==== hw/pbs_pkg.sv ====
// Types shared by the power button block.
package pbs_pkg;
  typedef enum logic [3:0] {
    PBS_WORK  = 4'h1,
    PBS_SLEEP = 4'h2,
    PBS_WAKE  = 4'h4,
    PBS_OFF   = 4'h8
  } pbs_state_t;
endpackage

// ==== hw/pbs_debounce.sv ====
// Level debouncer with a settle window of a given cycle count.
module pbs_debounce #(
  parameter int CYCLES = 1600000
) (
  input  wire logic pclk,     // System clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic raw_in,   // Undebounced input level.
  output logic      clean     // Debounced level, idles high.
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;
  wire          differs = (raw_in != clean);
  wire          settled = (cnt_r == W'(CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      clean <= 1'b1;
    end
    else if (!differs)
      cnt_r <= '0;
    else if (settled)
    begin
      cnt_r <= '0;
      clean <= raw_in;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule

// ==== hw/pbs_top.sv ====
// Power button, ring wake and sleep control block with an APB register file.
//
// Local design decisions: the address map and register access over APB.
`include "pbs_consts.svh"
module pbs_top #(
  parameter int DEBOUNCE_CYC = `PBS_DEBOUNCE_CYC,
  parameter int MS_CYC       = `PBS_MS_CYCLES,
  parameter int HOLD_MS      = `PBS_HOLD_MSEC
) (
  input  wire logic        pclk,                        // System clock, 100 MHz.
  input  wire logic        presetn,                     // Asynchronous reset, active low.
  input  wire logic        psel,                        // APB select.
  input  wire logic        penable,                     // APB access phase.
  input  wire logic        pwrite,                      // APB write.
  input  wire logic [11:0] paddr,                       // APB byte address.
  input  wire logic [31:0] pwdata,                      // APB write data.
  output logic      [31:0] prdata,                      // APB read data.
  output logic             pready,                      // APB ready.
  output logic             pslverr,                     // APB error.
  input  wire logic        power_button_n,              // Front panel button, active low.
  input  wire logic        ring_indicate_n,             // Ring indicate, active low.
  input  wire logic        resume_well_reset_n,         // Resume well reset, active low.
  input  wire logic        core_power_ok,               // Core power valid.
  output logic             sleep_state3_n,              // Sleep S3 output, active low.
  output logic             acpi_control_interrupt,      // Control interrupt level.
  output logic             system_management_interrupt, // Management interrupt level.
  output logic             irq                          // Block interrupt level.
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]             ctrl_r;
  logic [`PBS_NSTAT-1:0]  stat_r;
  logic [`PBS_NSTAT-1:0]  mask_r;
  pbs_pkg::pbs_state_t    state_r;
  pbs_pkg::pbs_state_t    state_nxt;
  logic                   btn_d_r;
  logic                   ring_d_r;
  logic [$clog2(MS_CYC+1)-1:0]  ms_cnt_r;
  logic [$clog2(HOLD_MS+1)-1:0] hold_ms_r;
  logic                   holding_r;
  logic                   btn_clean;

  pbs_debounce #(
    .CYCLES  (DEBOUNCE_CYC)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (power_button_n),
    .clean   (btn_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event decoding.
  wire press      = btn_d_r & ~btn_clean;
  wire ms_tick    = (ms_cnt_r == ($clog2(MS_CYC+1))'(MS_CYC - 1));
  wire hold_done  = holding_r & ~btn_clean & ms_tick
                    & (hold_ms_r == ($clog2(HOLD_MS+1))'(HOLD_MS - 1));
  wire in_work    = (state_r == pbs_pkg::PBS_WORK);
  wire core_off   = (state_r == pbs_pkg::PBS_SLEEP) | (state_r == pbs_pkg::PBS_OFF);
  wire ring_fall  = ring_d_r & ~ring_indicate_n;
  wire ring_wake  = ring_fall & core_off & ctrl_r[`PBS_CTRL_RING_EN];
  wire press_wake = press & core_off;
  wire ctl_ev     = press & in_work & ctrl_r[`PBS_CTRL_CTL_EN];
  wire mgt_ev     = press & in_work & ~ctrl_r[`PBS_CTRL_CTL_EN]
                    & ctrl_r[`PBS_CTRL_MGT_EN];
  wire [`PBS_NSTAT-1:0] ev = {ring_wake, hold_done, mgt_ev, ctl_ev,
                              press_wake | ring_wake, press & in_work};

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_c   = (paddr == `PBS_OFF_CTRL);
  wire hit_s   = (paddr == `PBS_OFF_STATUS);
  wire hit_m   = (paddr == `PBS_OFF_MASK);
  wire hit_st  = (paddr == `PBS_OFF_STATE);
  wire mapped  = hit_c | hit_s | hit_m | hit_st;
  wire [`PBS_NSTAT-1:0] w1c = (wr & hit_s) ? pwdata[`PBS_NSTAT-1:0] : '0;
  wire sleep_req = wr & hit_c & pwdata[`PBS_CTRL_SLEEP] & in_work;
  wire [31:0] rd_mux =
      hit_c  ? {28'h0000000, ctrl_r} :
      hit_s  ? {26'h0000000, stat_r} :
      hit_m  ? {26'h0000000, mask_r} :
      hit_st ? {26'h0000000, resume_well_reset_n, core_power_ok, state_r} :
               32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pbs_pkg::PBS_WORK:
        if (sleep_req)
          state_nxt = pbs_pkg::PBS_SLEEP;
      pbs_pkg::PBS_SLEEP, pbs_pkg::PBS_OFF:
        if (press_wake | ring_wake)
          state_nxt = pbs_pkg::PBS_WAKE;
      pbs_pkg::PBS_WAKE:
        if (core_power_ok & resume_well_reset_n)
          state_nxt = pbs_pkg::PBS_WORK;
      default:
        state_nxt = pbs_pkg::PBS_OFF;
    endcase
    if (hold_done)
      state_nxt = pbs_pkg::PBS_OFF;
    if (!resume_well_reset_n)
      state_nxt = pbs_pkg::PBS_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= pbs_pkg::PBS_OFF;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold timer, restarted by each new press.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_d_r   <= 1'b1;
      ring_d_r  <= 1'b1;
      holding_r <= 1'b0;
      ms_cnt_r  <= '0;
      hold_ms_r <= '0;
    end
    else
    begin
      btn_d_r  <= btn_clean;
      ring_d_r <= ring_indicate_n;
      if (press)
      begin
        holding_r <= 1'b1;
        ms_cnt_r  <= '0;
        hold_ms_r <= '0;
      end
      else if (btn_clean | hold_done)
        holding_r <= 1'b0;
      else if (holding_r)
      begin
        ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
        if (ms_tick)
          hold_ms_r <= hold_ms_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; a hardware set wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `PBS_CTRL_RST;
      mask_r <= `PBS_MASK_RST;
      stat_r <= '0;
    end
    else
    begin
      if (wr & hit_c)
        ctrl_r <= {1'b0, pwdata[2:0]};
      if (wr & hit_m)
        mask_r <= pwdata[`PBS_NSTAT-1:0];
      stat_r <= (stat_r & ~w1c) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata                      <= 32'h00000000;
      pready                      <= 1'b0;
      pslverr                     <= 1'b0;
      sleep_state3_n              <= 1'b0;
      acpi_control_interrupt      <= 1'b0;
      system_management_interrupt <= 1'b0;
      irq                         <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
      sleep_state3_n <= ~((state_nxt == pbs_pkg::PBS_SLEEP)
                          | (state_nxt == pbs_pkg::PBS_OFF));
      acpi_control_interrupt      <= stat_r[`PBS_ST_CTLINT];
      system_management_interrupt <= stat_r[`PBS_ST_MGTINT];
      irq <= |(stat_r & mask_r);
    end
  end
endmodule

// ==== sim/pbs_top_asserts.sv ====
// Port checker of the power button block.
module pbs_top_asserts #(
  parameter int DEBOUNCE_CYC = 4,
  parameter int MS_CYC       = 2,
  parameter int HOLD_MS      = 8
) (
  input wire logic pclk,                        // Clock.
  input wire logic presetn,                     // Reset.
  input wire logic psel,                        // Select.
  input wire logic power_button_n,              // Button.
  input wire logic ring_indicate_n,             // Ring.
  input wire logic resume_well_reset_n,         // Resume reset.
  input wire logic sleep_state3_n,              // Sleep out.
  input wire logic acpi_control_interrupt,      // Control int.
  input wire logic system_management_interrupt  // Mgmt int.
);
  localparam int hold_cyc = DEBOUNCE_CYC + HOLD_MS * MS_CYC;
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  // Counts the cycles the button has been held low.
  assign low_nxt = power_button_n ? 16'h0000 : low_r + 16'h0001;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_r <= 16'h0000;
    else
      low_r <= low_nxt;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_deb; ($rose(acpi_control_interrupt) || $rose(system_management_interrupt))
    |-> low_r >= DEBOUNCE_CYC; endproperty
  a_deb: assert property (p_deb) else $error("short press accepted");
  property p_wake; !sleep_state3_n && resume_well_reset_n && low_r == DEBOUNCE_CYC
    |-> ##[1:6] sleep_state3_n; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_ctl; $rose(acpi_control_interrupt) |-> $past(sleep_state3_n, 3); endproperty
  a_ctl: assert property (p_ctl) else $error("control int outside work");
  property p_mgt; $rose(system_management_interrupt) |-> !$rose(acpi_control_interrupt); endproperty
  a_mgt: assert property (p_mgt) else $error("both interrupts");
  property p_hold; low_r == hold_cyc + 3 |-> ##[0:4] !sleep_state3_n; endproperty
  a_hold: assert property (p_hold) else $error("no override");
  property p_cause; $rose(sleep_state3_n) |-> low_r >= DEBOUNCE_CYC || !ring_indicate_n; endproperty
  a_cause: assert property (p_cause) else $error("wake without cause");
  property p_rst; $fell(sleep_state3_n) && !$past(psel) && !$past(psel, 2)
    && $past(resume_well_reset_n) |-> low_r >= hold_cyc; endproperty
  a_rst: assert property (p_rst) else $error("early override");
  c_wake: cover property ($rose(sleep_state3_n));
  c_ctl: cover property ($rose(acpi_control_interrupt));
  c_hold: cover property ($fell(sleep_state3_n) && low_r > 16'h0000);
endmodule
bind pbs_top pbs_top_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .MS_CYC(MS_CYC), .HOLD_MS(HOLD_MS))
  u_chk (.pclk, .presetn, .psel, .power_button_n, .ring_indicate_n, .resume_well_reset_n,
  .sleep_state3_n, .acpi_control_interrupt, .system_management_interrupt);

// ==== sim/pbs_board.sv ====
// Board power sequencing model facing the power button block.
module pbs_board #(
  parameter int DLY = 2
) (
  input  wire logic pclk,                       // Clock.
  input  wire logic standby_ok,                 // Standby up.
  input  wire logic sleep_state3_n,             // Sleep out.
  output logic      supply_on_control,          // Supply on.
  output logic      resume_well_reset_n = 1'b0, // Resume reset.
  output logic      core_power_ok = 1'b0        // Core ok.
);
  timeunit 1ns;
  timeprecision 1ns;
  int rsm_cnt = 0;
  int core_cnt = 0;
  assign supply_on_control = ~sleep_state3_n;
  always @(posedge pclk)
  begin
    rsm_cnt <= standby_ok ? (rsm_cnt < DLY ? rsm_cnt + 1 : DLY) : 0;
    resume_well_reset_n <= standby_ok && rsm_cnt >= DLY;
    core_cnt <= supply_on_control ? 0 : (core_cnt < DLY ? core_cnt + 1 : DLY);
    core_power_ok <= resume_well_reset_n && core_cnt >= DLY;
  end
endmodule

// ==== sim/pbs_top_test.sv ====
// Self-checking bench of the power button block.
module pbs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int D = 4;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        power_button_n = 1'b1, ring_indicate_n = 1'b1, standby_ok = 1'b1;
  logic        pready, pslverr, resume_well_reset_n, core_power_ok, sleep_state3_n, irq;
  logic        acpi_control_interrupt, system_management_interrupt;
  logic [32:0] exp_q[$], msk_q[$];
  int          num_errors = 0, compares = 0;
  always #5 pclk = ~pclk;
  pbs_top #(.DEBOUNCE_CYC(D), .MS_CYC(2), .HOLD_MS(8)) dut (.*);
  pbs_board #(.DLY(2)) board (.*, .supply_on_control());
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
    compares++;
    if ((got & m) !== (exp & m))
    begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    check({32'h0, got}, {32'h0, exp}, 33'h1);
  endtask
  task automatic conclude;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e = 33'h0, input logic [32:0] m = {33{1'b1}});
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(negedge pclk);
      if (pready === 1'b1)
        break;
    end
    @(posedge pclk);
    if (n >= 20)
    begin
      num_errors++;
      conclude();
    end
    else
      {psel, penable} <= 2'b00;
  endtask
  task automatic press(input int n);
    @(posedge pclk);
    power_button_n <= 1'b0;
    repeat (n) @(posedge pclk);
    power_button_n <= 1'b1;
    cyc(D + 4);
  endtask
  task automatic wait_pok;
    int n;
    for (n = 0; n < 100 && core_power_ok !== 1'b1; n++)
      cyc(1);
    if (n >= 100)
    begin
      num_errors++;
      conclude();
    end
    cyc(3);
  endtask
  // Read data is compared mid-cycle while the access phase stands.
  always @(negedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
  end
  initial
  begin
    cyc(10);
    presetn <= 1'b1;
    void'($urandom(27));
    xfer(1'b0, 12'h00C, '0, 33'h028, 33'h03F);
    xfer(1'b0, 12'h010, '0, {1'b1, 32'h0});
    press(1 + $urandom % (D - 1));
    xfer(1'b0, 12'h004, '0, 33'h000);
    press(D + 4);
    wait_pok();
    xfer(1'b0, 12'h00C, '0, 33'h031, 33'h03F);
    xfer(1'b0, 12'h004, '0, 33'h002);
    xfer(1'b1, 12'h004, 32'h3F);
    for (int c = 0; c < 3; c++)
    begin
      xfer(1'b1, 12'h000, 32'(c));
      press(D + 4);
      pin(acpi_control_interrupt, c == 1);
      pin(system_management_interrupt, c == 2);
      xfer(1'b0, 12'h004, '0, {29'h0, c == 2, c == 1, 2'b01});
      xfer(1'b1, 12'h008, 32'h0);
      cyc(2);
      pin(irq, 1'b0);
      xfer(1'b1, 12'h008, 32'h3F);
      cyc(2);
      pin(irq, 1'b1);
      xfer(1'b1, 12'h004, 32'h3F);
      cyc(2);
      pin(irq, 1'b0);
    end
    pin(sleep_state3_n, 1'b1);
    xfer(1'b1, 12'h000, 32'h8);
    cyc(2);
    pin(sleep_state3_n, 1'b0);
    xfer(1'b0, 12'h00C, '0, 33'h022, 33'h03F);
    press(D + 4);
    wait_pok();
    xfer(1'b0, 12'h004, '0, 33'h002);
    xfer(1'b1, 12'h004, 32'h3F);
    xfer(1'b1, 12'h000, 32'h0);
    press(D + 24);
    pin(sleep_state3_n, 1'b0);
    xfer(1'b0, 12'h004, '0, 33'h011);
    xfer(1'b1, 12'h004, 32'h3F);
    xfer(1'b1, 12'h000, 32'h4);
    @(posedge pclk);
    ring_indicate_n <= 1'b0;
    cyc(10);
    ring_indicate_n <= 1'b1;
    wait_pok();
    xfer(1'b0, 12'h004, '0, 33'h020, 33'h020);
    standby_ok <= 1'b0;
    cyc(6);
    xfer(1'b0, 12'h00C, '0, 33'h008, 33'h03F);
    cyc(2);
    conclude();
  end
endmodule
